// ---- ahx_cfg_regs.vh ----
// Register addresses, field positions and reset values of the header translation register bank.
`ifndef AHX_CFG_REGS_VH
`define AHX_CFG_REGS_VH
`define AHX_ADDR_SEARCH_CFG 16'h8001
`define AHX_ADDR_DATAPATH_CFG 16'h8002
`define AHX_ADDR_TABLE_BASE 16'h8003
`define AHX_ADDR_PIN_CTRL 16'h8004
`define AHX_ADDR_TX_TAG 16'h8005
`define AHX_ADDR_RX_TAG 16'h8006
`define AHX_ADDR_NOTIFY_EN 16'h8007
`define AHX_ADDR_EVENT_STATUS 16'h8008
`define AHX_RST_SEARCH_CFG 8'h00
`define AHX_RST_DATAPATH_CFG 8'h00
`define AHX_RST_TABLE_BASE 8'h00
`define AHX_RST_PIN_CTRL 8'h00
`define AHX_RST_NOTIFY_EN 8'h00
`define AHX_RST_EVENT_STATUS 8'h00
`define AHX_RST_TX_TAG 8'h00
`define AHX_RST_RX_TAG 8'h00
`define AHX_MASK_SEARCH_CFG 8'hfb
`define AHX_MASK_DATAPATH_CFG 8'h7f
`define AHX_MASK_PIN_CTRL 8'h7f
`define AHX_MASK_TX_TAG 8'h1f
`define AHX_MASK_RX_TAG 8'h7f
`define AHX_MASK_RX_TAG_STRAP 8'h3f
`define AHX_MASK_EVENTS 8'h07
`define AHX_SC_ACCOUNT 3
`define AHX_SC_NULL_COUNT 4
`define AHX_SC_GFC 5
`define AHX_SC_PTCLP 6
`define AHX_SC_PASS_ALL 7
`define AHX_DP_INSERT 0
`define AHX_DP_OVR_GFC 1
`define AHX_DP_OVR_PTCLP 2
`define AHX_DP_RX_MOVE 3
`define AHX_DP_TX_MOVE 4
`define AHX_DP_DROP_FULL 5
`define AHX_DP_RX_DISCARD 6
`define AHX_PC_OVERRIDE 0
`define AHX_PC_CTRL_A 1
`define AHX_PC_CTRL_B 2
`define AHX_PC_EE_MUX 3
`define AHX_PC_EE_CLK 4
`define AHX_PC_EE_CS_N 5
`define AHX_PC_EE_DOUT 6
`define AHX_PC_EE_DIN 7
`define AHX_TAG_SIZE_HI 2
`define AHX_TAG_SIZE_LO 0
`define AHX_TX_AT_END 3
`define AHX_TX_ADD_HEC 4
`define AHX_RX_DEL_HEC 3
`define AHX_RX_CLK_IN 4
`define AHX_RX_INBAND_UTOPIA 5
`define AHX_RX_EE_INIT 6
`define AHX_TB_SEARCH_HI 5
`define AHX_TB_SEARCH_LO 0
`define AHX_TB_RESULT_HI 7
`define AHX_TB_RESULT_LO 6
`define AHX_EV_PHY 0
`define AHX_EV_RX_NULL 1
`define AHX_EV_TX_NULL 2
`define AHX_LEVELS_BASE 4'h8
`define AHX_LEVELS_PTCLP 4'ha
`define AHX_RESULT_WORDS_BASE 3'h2
`define AHX_RESULT_WORDS_ACCOUNT 3'h4
`endif

// ---- ahx_cfg_regs.v ----
// Configuration, control and status register bank of the cell header translation device.
//
// How it works
// RQ1 - Accounting bit: count per connection, four-word nodes.
// RQ2 - Bit four enables null-pointer cell counters.
// RQ3 - Bit five adds GFC, table grows 4K.
// RQ4 - Bit six adds PT/CLP, ten search levels.
// RQ5 - Null-pointer cells dropped unless pass-all set.
// RQ6 - Insert bit replaces header with searched one.
// RQ7 - GFC and PT/CLP overwritten only when enabled.
// RQ8 - PT/CLP moved to or from TAG area.
// RQ9 - Full PHY FIFO: stall, or drop if set.
// RQ10 - Receive data cells dropped; in-band cells kept only when in-band port is UTOPIA.
// RQ11 - Table base: search base, result node base.
// RQ12 - Strapped registers writable only under override bit; receive TAG bit 6 (EEPROM init) is writable without it.
// RQ13 - Two control pins follow their register bits.
// RQ14 - EEPROM port: loader or software bits.
// RQ15 - Software drives EEPROM clock, select, data out.
// RQ16 - Transmit strips TAG bytes, may add HEC.
// RQ17 - Receive adds TAG bytes, may delete HEC.
// RQ18 - Mode bit sets path receive clock direction.
// RQ19 - Direction bit picks in-band programming port.
// RQ20 - EEPROM header load at reset when enabled.
// RQ21 - Notification cells only for enabled events.
// RQ22 - Status bits set on their events.
// RQ23 - Status sticky until written; unused bits zero.
`timescale 1ns/1ps
`default_nettype none
`include "ahx_cfg_regs.vh"

module ahx_cfg_regs (
	input wire ref_clk,
	input wire rst,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [7:0] strap_tx_tag,
	input wire [7:0] strap_rx_tag,
	input wire phy_interrupt_input,
	input wire rx_null_event,
	input wire tx_null_event,
	input wire rx_cell_is_inband,
	input wire phy_tx_fifo_full,
	output wire count_per_connection,
	output wire [2:0] result_node_words,
	output wire null_count_enable,
	output wire search_include_gfc,
	output wire search_table_4k,
	output wire [3:0] search_tree_levels,
	output wire pass_null_cells,
	output wire replace_header,
	output wire overwrite_gfc,
	output wire overwrite_ptclp,
	output wire rx_move_ptclp_to_tag,
	output wire tx_move_ptclp_from_tag,
	output wire tx_stall,
	output wire tx_drop_cell,
	output wire receive_data_discard,
	output wire [5:0] search_table_base,
	output wire [1:0] result_node_base,
	output reg ctrl_a_out,
	output reg ctrl_b_out,
	output wire ee_sw_mode,
	input wire loader_ee_clk,
	input wire loader_ee_cs_n,
	input wire loader_ee_dout,
	output reg ee_clk,
	output reg ee_cs_n,
	output reg ee_dout,
	input wire ee_din,
	output wire [2:0] tx_tag_strip_bytes,
	output wire tx_tag_at_end,
	output wire tx_add_hec,
	output wire [2:0] rx_tag_add_bytes,
	output wire rx_delete_hec,
	output wire path_receive_clock_oe,
	output wire inband_on_utopia,
	output wire ee_header_load_enable,
	output wire notify_phy,
	output wire notify_rx_null,
	output wire notify_tx_null
);

	// ************************************************************
	// Register state.
	// ************************************************************
	reg [7:0] search_config_reg;
	reg [7:0] datapath_config_reg;
	reg [7:0] table_base_offsets_reg;
	reg [7:0] pin_and_eeprom_control_reg;
	reg [7:0] transmit_tag_setup_reg;
	reg [7:0] receive_tag_and_mode_reg;
	reg [7:0] notification_enable_reg;
	reg [7:0] event_status_reg;
	reg strap_loaded_reg;
	reg ee_din_reg;
	wire [7:0] event_vec;
	wire strap_wr_ok;

	assign strap_wr_ok = pin_and_eeprom_control_reg[`AHX_PC_OVERRIDE]; // RQ12

	// ************************************************************
	// Register writes and strap capture.
	// ************************************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			search_config_reg <= `AHX_RST_SEARCH_CFG;
			datapath_config_reg <= `AHX_RST_DATAPATH_CFG;
			table_base_offsets_reg <= `AHX_RST_TABLE_BASE;
			pin_and_eeprom_control_reg <= `AHX_RST_PIN_CTRL;
			transmit_tag_setup_reg <= `AHX_RST_TX_TAG;
			receive_tag_and_mode_reg <= `AHX_RST_RX_TAG;
			notification_enable_reg <= `AHX_RST_NOTIFY_EN;
			strap_loaded_reg <= 1'b0;
		end else begin
			if (!strap_loaded_reg) begin
				strap_loaded_reg <= 1'b1;
				transmit_tag_setup_reg <= strap_tx_tag & `AHX_MASK_TX_TAG;
				receive_tag_and_mode_reg <= strap_rx_tag & `AHX_MASK_RX_TAG_STRAP;
			end else if (reg_wr) begin
				case (reg_addr)
				`AHX_ADDR_SEARCH_CFG: begin
					search_config_reg <= reg_wdata & `AHX_MASK_SEARCH_CFG;
				end
				`AHX_ADDR_DATAPATH_CFG: begin
					datapath_config_reg <= reg_wdata & `AHX_MASK_DATAPATH_CFG;
				end
				`AHX_ADDR_TABLE_BASE: begin
					table_base_offsets_reg <= reg_wdata; // RQ11
				end
				`AHX_ADDR_PIN_CTRL: begin
					pin_and_eeprom_control_reg <= reg_wdata & `AHX_MASK_PIN_CTRL;
				end
				`AHX_ADDR_TX_TAG: begin
					if (strap_wr_ok) begin
						transmit_tag_setup_reg <= reg_wdata & `AHX_MASK_TX_TAG; // RQ12
					end
				end
				`AHX_ADDR_RX_TAG: begin
					if (strap_wr_ok) begin
						receive_tag_and_mode_reg <= reg_wdata & `AHX_MASK_RX_TAG; // RQ12
					end else begin
						receive_tag_and_mode_reg[`AHX_RX_EE_INIT] <= reg_wdata[`AHX_RX_EE_INIT];
					end
				end
				`AHX_ADDR_NOTIFY_EN: begin
					notification_enable_reg <= reg_wdata & `AHX_MASK_EVENTS;
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ************************************************************
	// Sticky event status.
	// ************************************************************
	assign event_vec = {5'h00, tx_null_event, rx_null_event, phy_interrupt_input}; // RQ22

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			event_status_reg <= `AHX_RST_EVENT_STATUS;
		end else if (reg_wr && (reg_addr == `AHX_ADDR_EVENT_STATUS)) begin
			event_status_reg <= event_vec & `AHX_MASK_EVENTS; // RQ23
		end else begin
			event_status_reg <= (event_status_reg | event_vec) & `AHX_MASK_EVENTS; // RQ22
		end
	end

	// ************************************************************
	// Read port.
	// ************************************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
			`AHX_ADDR_SEARCH_CFG: begin
				reg_rdata <= search_config_reg;
			end
			`AHX_ADDR_DATAPATH_CFG: begin
				reg_rdata <= datapath_config_reg;
			end
			`AHX_ADDR_TABLE_BASE: begin
				reg_rdata <= table_base_offsets_reg;
			end
			`AHX_ADDR_PIN_CTRL: begin
				reg_rdata <= {ee_din_reg, pin_and_eeprom_control_reg[6:0]}; // RQ15
			end
			`AHX_ADDR_TX_TAG: begin
				reg_rdata <= transmit_tag_setup_reg;
			end
			`AHX_ADDR_RX_TAG: begin
				reg_rdata <= receive_tag_and_mode_reg;
			end
			`AHX_ADDR_NOTIFY_EN: begin
				reg_rdata <= notification_enable_reg;
			end
			`AHX_ADDR_EVENT_STATUS: begin
				reg_rdata <= event_status_reg;
			end
			default: begin
				reg_rdata <= 8'h00; // RQ23
			end
			endcase
		end
	end

	// ************************************************************
	// Control and EEPROM pins.
	// ************************************************************
	assign ee_sw_mode = pin_and_eeprom_control_reg[`AHX_PC_EE_MUX]; // RQ14

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl_a_out <= 1'b0;
			ctrl_b_out <= 1'b0;
			ee_clk <= 1'b0;
			ee_cs_n <= 1'b1;
			ee_dout <= 1'b0;
			ee_din_reg <= 1'b0;
		end else begin
			ctrl_a_out <= pin_and_eeprom_control_reg[`AHX_PC_CTRL_A]; // RQ13
			ctrl_b_out <= pin_and_eeprom_control_reg[`AHX_PC_CTRL_B]; // RQ13
			ee_din_reg <= ee_din; // RQ15
			if (ee_sw_mode) begin
				ee_clk <= pin_and_eeprom_control_reg[`AHX_PC_EE_CLK]; // RQ15
				ee_cs_n <= pin_and_eeprom_control_reg[`AHX_PC_EE_CS_N]; // RQ15
				ee_dout <= pin_and_eeprom_control_reg[`AHX_PC_EE_DOUT]; // RQ15
			end else begin
				ee_clk <= loader_ee_clk; // RQ14
				ee_cs_n <= loader_ee_cs_n; // RQ14
				ee_dout <= loader_ee_dout; // RQ14
			end
		end
	end

	// ************************************************************
	// Decoded controls to the data path.
	// ************************************************************
	assign count_per_connection = search_config_reg[`AHX_SC_ACCOUNT]; // RQ1
	assign result_node_words = count_per_connection ? `AHX_RESULT_WORDS_ACCOUNT :
		`AHX_RESULT_WORDS_BASE; // RQ1
	assign null_count_enable = search_config_reg[`AHX_SC_NULL_COUNT]; // RQ2
	assign search_include_gfc = search_config_reg[`AHX_SC_GFC]; // RQ3
	assign search_table_4k = search_include_gfc; // RQ3
	assign search_tree_levels = search_config_reg[`AHX_SC_PTCLP] ? `AHX_LEVELS_PTCLP :
		`AHX_LEVELS_BASE; // RQ4
	assign pass_null_cells = search_config_reg[`AHX_SC_PASS_ALL]; // RQ5
	assign replace_header = datapath_config_reg[`AHX_DP_INSERT]; // RQ6
	assign overwrite_gfc = replace_header & datapath_config_reg[`AHX_DP_OVR_GFC]; // RQ7
	assign overwrite_ptclp = replace_header & datapath_config_reg[`AHX_DP_OVR_PTCLP]; // RQ7
	assign rx_move_ptclp_to_tag = datapath_config_reg[`AHX_DP_RX_MOVE]; // RQ8
	assign tx_move_ptclp_from_tag = datapath_config_reg[`AHX_DP_TX_MOVE]; // RQ8
	assign tx_stall = phy_tx_fifo_full & ~datapath_config_reg[`AHX_DP_DROP_FULL]; // RQ9
	assign tx_drop_cell = phy_tx_fifo_full & datapath_config_reg[`AHX_DP_DROP_FULL]; // RQ9
	assign receive_data_discard = datapath_config_reg[`AHX_DP_RX_DISCARD] &
		~(rx_cell_is_inband & inband_on_utopia); // RQ10
	assign search_table_base = table_base_offsets_reg[`AHX_TB_SEARCH_HI:`AHX_TB_SEARCH_LO]; // RQ11
	assign result_node_base = table_base_offsets_reg[`AHX_TB_RESULT_HI:`AHX_TB_RESULT_LO]; // RQ11
	assign tx_tag_strip_bytes = transmit_tag_setup_reg[`AHX_TAG_SIZE_HI:`AHX_TAG_SIZE_LO]; // RQ16
	assign tx_tag_at_end = transmit_tag_setup_reg[`AHX_TX_AT_END]; // RQ16
	assign tx_add_hec = transmit_tag_setup_reg[`AHX_TX_ADD_HEC]; // RQ16
	assign rx_tag_add_bytes = receive_tag_and_mode_reg[`AHX_TAG_SIZE_HI:`AHX_TAG_SIZE_LO]; // RQ17
	assign rx_delete_hec = receive_tag_and_mode_reg[`AHX_RX_DEL_HEC]; // RQ17
	assign path_receive_clock_oe = ~receive_tag_and_mode_reg[`AHX_RX_CLK_IN]; // RQ18
	assign inband_on_utopia = receive_tag_and_mode_reg[`AHX_RX_INBAND_UTOPIA]; // RQ19
	assign ee_header_load_enable = receive_tag_and_mode_reg[`AHX_RX_EE_INIT]; // RQ20
	assign notify_phy = phy_interrupt_input & notification_enable_reg[`AHX_EV_PHY]; // RQ21
	assign notify_rx_null = rx_null_event & notification_enable_reg[`AHX_EV_RX_NULL]; // RQ21
	assign notify_tx_null = tx_null_event & notification_enable_reg[`AHX_EV_TX_NULL]; // RQ21

endmodule // ahx_cfg_regs
`default_nettype wire

// ---- ahx_cfg_regs_properties.sv ----
// Checker of the header translation register bank.
`timescale 1ns/1ps
`default_nettype none
module ahx_cfg_regs_properties (
	input wire ref_clk,
	input wire rst,
	input wire [15:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire phy_interrupt_input,
	input wire rx_cell_is_inband,
	input wire inband_on_utopia,
	input wire phy_tx_fifo_full,
	input wire loader_ee_clk,
	input wire [3:0] search_tree_levels,
	input wire [2:0] result_node_words,
	input wire replace_header,
	input wire overwrite_gfc,
	input wire tx_stall,
	input wire tx_drop_cell,
	input wire receive_data_discard,
	input wire ctrl_a_out,
	input wire ee_sw_mode,
	input wire ee_clk,
	input wire [2:0] tx_tag_strip_bytes,
	input wire notify_phy
);
// ****************************************
// Assertions and covers.
// ****************************************
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
wire w_cfg = reg_wr && reg_addr == 16'h8001;
wire w_pin = reg_wr && reg_addr == 16'h8004;
wire w_tx = reg_wr && reg_addr == 16'h8005;
a_tree_levels: assert property (w_cfg |=>
	search_tree_levels == ($past(reg_wdata[6]) ? 4'ha : 4'h8) &&
	result_node_words == ($past(reg_wdata[3]) ? 3'h4 : 3'h2)) else $error("tree size wrong");
a_ctrl_pin: assert property (w_pin |-> ##2 ctrl_a_out == $past(reg_wdata[1], 2))
	else $error("control pin wrong");
a_stall_drop: assert property ((tx_stall || tx_drop_cell) == phy_tx_fifo_full
	&& !(tx_stall && tx_drop_cell)) else $error("full action wrong");
a_inband_kept: assert property (rx_cell_is_inband && inband_on_utopia |-> !receive_data_discard)
	else $error("in-band cell dropped");
a_notify_cause: assert property (notify_phy |-> phy_interrupt_input)
	else $error("notify without event");
a_overwrite_gated: assert property (overwrite_gfc |-> replace_header)
	else $error("overwrite without insert");
a_unused_zero: assert property (reg_rd && reg_addr == 16'h8008 |=> reg_rdata[7:3] == 5'h00)
	else $error("status unused bits set");
a_strap_locked: assert property (!$past(rst) && !$past(rst, 2) && !$past(w_tx)
	|-> $stable(tx_tag_strip_bytes)) else $error("tag size moved");
a_ee_loader: assert property (!$past(ee_sw_mode) && !$past(rst)
	|-> ee_clk == $past(loader_ee_clk)) else $error("loader clock wrong");
cover property (w_cfg);
cover property (notify_phy);
cover property (tx_drop_cell);
endmodule // ahx_cfg_regs_properties
`default_nettype wire

// ---- tb_ahx_cfg_regs.sv ----
// Self-checking bench of the header translation register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_ahx_cfg_regs;
// ****************************************
// Signals, tasks and scenarios.
// ****************************************
logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, phy_tx_fifo_full = 0, rx_cell_is_inband = 0;
logic [15:0] reg_addr = 0;
logic [7:0] reg_wdata = 0, strap_tx_tag = 8'hf5, strap_rx_tag = 8'hff, d;
logic phy_interrupt_input = 0, rx_null_event = 0, tx_null_event = 0, ee_din = 0;
logic loader_ee_clk = 0, loader_ee_cs_n = 1, loader_ee_dout = 1;
wire [7:0] reg_rdata;
wire [5:0] search_table_base;
wire [3:0] search_tree_levels;
wire [2:0] result_node_words, tx_tag_strip_bytes, rx_tag_add_bytes;
wire [1:0] result_node_base;
wire count_per_connection, null_count_enable, search_include_gfc, search_table_4k;
wire pass_null_cells, replace_header, overwrite_gfc, overwrite_ptclp, rx_move_ptclp_to_tag;
wire tx_move_ptclp_from_tag, tx_stall, tx_drop_cell, receive_data_discard, ctrl_a_out;
wire ctrl_b_out, ee_sw_mode, ee_clk, ee_cs_n, ee_dout, tx_tag_at_end, tx_add_hec;
wire rx_delete_hec, path_receive_clock_oe, inband_on_utopia, ee_header_load_enable;
wire notify_phy, notify_rx_null, notify_tx_null;
int n_mismatch = 0, num_checks = 0, cyc = 0;
ahx_cfg_regs DUT (.*);
always #5 ref_clk = ~ref_clk;
task automatic test_done;
	$display("checks %0d mismatches %0d", num_checks, n_mismatch);
	if (n_mismatch == 0 && num_checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
always @(posedge ref_clk) begin
	cyc <= cyc + 1;
	if (cyc == 2000) begin
		n_mismatch++;
		test_done;
	end
end
task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
	num_checks++;
	if (g !== e) begin
		n_mismatch++;
		$display("wrong value %s expected %h seen %h", s, e, g);
	end
endtask
task automatic wr(input logic [15:0] a, input logic [7:0] v);
	@(posedge ref_clk);
	{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
	@(posedge ref_clk);
	reg_wr <= 0;
	#1;
endtask
task automatic rdc(input logic [15:0] a, input logic [7:0] e);
	@(posedge ref_clk);
	{reg_rd, reg_addr} <= {1'b1, a};
	@(posedge ref_clk);
	reg_rd <= 0;
	#1 cmp("reg_rdata", e, reg_rdata);
endtask
task automatic ev(input logic [2:0] v);
	@(posedge ref_clk);
	{tx_null_event, rx_null_event, phy_interrupt_input} <= v;
	#1 d = {5'h00, notify_tx_null, notify_rx_null, notify_phy};
	@(posedge ref_clk);
	{tx_null_event, rx_null_event, phy_interrupt_input} <= 3'h0;
endtask
task automatic t_reset;
	rdc(16'h8001, 8'h00);
	rdc(16'h8005, 8'h15);
	rdc(16'h8006, 8'h3f);
	cmp("tag_fields", 8'h5f, {tx_tag_strip_bytes, tx_add_hec, rx_tag_add_bytes});
	cmp("path_receive_clock_oe", 0, path_receive_clock_oe);
	wr(16'h8009, 8'hff);
	rdc(16'h8009, 8'h00);
endtask
task automatic t_search;
	wr(16'h8001, 8'hff);
	rdc(16'h8001, 8'hfb);
	cmp("search_tree_levels", 8'h0a, search_tree_levels);
	cmp("result_node_words", 8'h04, result_node_words);
	cmp("search_flags", 8'h0f, {count_per_connection, null_count_enable, search_table_4k, pass_null_cells});
	wr(16'h8001, 8'h00);
	cmp("search_tree_levels", 8'h08, search_tree_levels);
	cmp("search_flags", 8'h00, {count_per_connection, null_count_enable, search_table_4k, pass_null_cells});
	cmp("result_node_words", 8'h02, result_node_words);
	wr(16'h8003, 8'hc5);
	cmp("table_bases", 8'hc5, {result_node_base, search_table_base});
endtask
task automatic t_strap;
	wr(16'h8005, 8'h0a);
	rdc(16'h8005, 8'h15);
	wr(16'h8006, 8'h40);
	rdc(16'h8006, 8'h7f);
	cmp("ee_header_load_enable", 1, ee_header_load_enable);
	wr(16'h8004, 8'h01);
	wr(16'h8005, 8'h0a);
	rdc(16'h8005, 8'h0a);
	cmp("tx_tag_at_end", 1, tx_tag_at_end);
	wr(16'h8006, 8'h08);
	cmp("rx_modes", 8'h06, {path_receive_clock_oe, rx_delete_hec, inband_on_utopia});
endtask
task automatic t_pins;
	cmp("ee_loader", 8'h03, {ee_clk, ee_cs_n, ee_dout});
	wr(16'h8004, 8'h1c);
	@(posedge ref_clk);
	ee_din <= 1;
	#1 cmp("ctrl_pins", 8'h01, {ctrl_a_out, ctrl_b_out});
	cmp("ee_soft", 8'h04, {ee_clk, ee_cs_n, ee_dout});
	rdc(16'h8004, 8'h9c);
endtask
task automatic t_events;
	wr(16'h8007, 8'hff);
	rdc(16'h8007, 8'h07);
	wr(16'h8007, 8'h05);
	ev(3'h3);
	cmp("notify", 8'h01, d);
	rdc(16'h8008, 8'h03);
	rdc(16'h8008, 8'h03);
	wr(16'h8008, 8'h00);
	rdc(16'h8008, 8'h00);
	ev(3'h4);
	cmp("notify", 8'h04, d);
	rdc(16'h8008, 8'h04);
endtask
task automatic t_dp;
	wr(16'h8002, 8'h06);
	cmp("overwrite_gfc", 0, overwrite_gfc);
	wr(16'h8002, 8'hff);
	rdc(16'h8002, 8'h7f);
	cmp("dp_flags", 8'h0f, {replace_header, overwrite_ptclp, rx_move_ptclp_to_tag, tx_move_ptclp_from_tag});
	@(posedge ref_clk);
	phy_tx_fifo_full <= 1;
	#1 cmp("full_action", 8'h03, {tx_stall, tx_drop_cell, receive_data_discard});
	@(posedge ref_clk);
	rx_cell_is_inband <= 1;
	#1 cmp("receive_data_discard", 1, receive_data_discard);
	wr(16'h8004, 8'h01);
	wr(16'h8006, 8'h20);
	cmp("inband_on_utopia", 1, inband_on_utopia);
	cmp("receive_data_discard", 0, receive_data_discard);
	wr(16'h8002, 8'h00);
	cmp("full_action", 8'h04, {tx_stall, tx_drop_cell, receive_data_discard});
endtask
initial begin
	repeat (6) @(posedge ref_clk);
	rst <= 0;
	repeat (2) @(posedge ref_clk);
	t_reset;
	t_search;
	t_strap;
	t_pins;
	t_events;
	t_dp;
	test_done;
end
endmodule // tb_ahx_cfg_regs
bind ahx_cfg_regs ahx_cfg_regs_properties u_chk (.*);
`default_nettype wire
